// file: rtl/buck_regulator_i2c_register_bank.sv
`timescale 1ns/1ps
module buck_regulator_i2c_register_bank (
	input  wire logic       clock_i,
	input  wire logic       srst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       hw_enable_i,
	input  wire logic       select_second_i,
	input  wire logic       thermal_trip_i,
	input  wire logic       power_bad_i,
	output logic [6:0]      first_voltage_code_o,
	output logic [6:0]      second_voltage_code_o,
	output logic [6:0]      active_voltage_code_o,
	output logic            forced_pulse_width_switching_o,
	output logic            ramp_forced_pwm_o,
	output logic [1:0]      ramp_speed_o,
	output logic            converter_enable_o,
	output logic            output_discharge_o,
	output logic            soft_restart_o,
	output logic            quick_restart_o
);
	import regbank_pkg::*;

	reg_access_if ra ();

	logic [5:0] pins_s;
	logic       scl_s, sda_s, hw_en_s, sel2_s, therm_s, pbad_s;

	////////////////////////////////////////////////////////////////////////////
	// pins from outside the clock domain
	pin_sync #(.W(6), .INIT(PIN_IDLE)) u_sync (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.d_i     ({scl_i, sda_i, hw_enable_i, select_second_i, thermal_trip_i, power_bad_i}),
		.q_o     (pins_s)
	);
	assign {scl_s, sda_s, hw_en_s, sel2_s, therm_s, pbad_s} = pins_s;

	i2c_target_engine u_eng (
		.clock_i  (clock_i),
		.srst_i   (srst_i),
		.scl_i    (scl_s),
		.sda_i    (sda_s),
		.sda_oe_o (sda_oe_o),
		.ra       (ra.engine)
	);
	// open drain: only ever pulls low
	assign sda_o = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [6:0] vout1_r, vout1_nxt;
	logic [7:0] vout2_r, vout2_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic       disch_hold_r, disch_hold_nxt;
	logic       enable_d_r;
	logic       soft_rst_r, soft_rst_nxt;
	logic       quick_r, quick_nxt;
	logic       wr_v1, wr_v2, wr_ctrl, rd_flags;
	logic       enable_now;

	assign wr_v1    = ra.wr_stb & reg_hit(ra.sel, OFS_VOUT1);
	assign wr_v2    = ra.wr_stb & reg_hit(ra.sel, OFS_VOUT2);
	assign wr_ctrl  = ra.wr_stb & reg_hit(ra.sel, OFS_CTRL);
	assign rd_flags = ra.rd_stb & reg_hit(ra.sel, OFS_FLAGS);
	assign enable_now = ctrl_r[B_SW_EN] & hw_en_s;

	// write decode; the reset bit wins over every other field in the same byte
	always_comb
	begin
		vout1_nxt    = vout1_r;
		vout2_nxt    = vout2_r;
		ctrl_nxt     = ctrl_r;
		flags_nxt    = flags_r;
		soft_rst_nxt = 1'b0;
		quick_nxt    = 1'b0;
		if (wr_v1)
			vout1_nxt = ra.wdata[6:0]; // R03
		if (wr_v2)
			vout2_nxt = ra.wdata; // R03 R05
		if (wr_ctrl)
		begin
			ctrl_nxt           = ra.wdata;
			ctrl_nxt[B_SRST]   = 1'b0; // R07
			ctrl_nxt[B_RSVD]   = 1'b0; // R15
			quick_nxt          = ra.wdata[B_SW_EN] & ~ctrl_r[B_SW_EN]; // R09
		end
		// clear on read first, so a new event in the same cycle survives
		if (rd_flags)
			flags_nxt = FLAGS_RST; // R06
		if (therm_s)
			flags_nxt[B_THERMAL] = 1'b1;
		if (pbad_s)
			flags_nxt[B_PBAD] = 1'b1;
		if (wr_ctrl && ra.wdata[B_SRST])
		begin
			vout1_nxt    = VOUT1_RST; // R07
			vout2_nxt    = VOUT2_RST;
			ctrl_nxt     = CTRL_RST;
			flags_nxt    = FLAGS_RST;
			soft_rst_nxt = 1'b1;
			quick_nxt    = 1'b0;
		end
	end

	// discharge choice is frozen when the converter turns off
	always_comb
	begin
		disch_hold_nxt = disch_hold_r;
		if (enable_d_r && !enable_now)
			disch_hold_nxt = ctrl_r[B_DISCH]; // R11
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			vout1_r      <= VOUT1_RST; // R04
			vout2_r      <= VOUT2_RST; // R04
			ctrl_r       <= CTRL_RST;
			flags_r      <= FLAGS_RST; // R06
			disch_hold_r <= CTRL_RST[B_DISCH];
			enable_d_r   <= 1'b0;
			soft_rst_r   <= 1'b0;
			quick_r      <= 1'b0;
		end
		else
		begin
			vout1_r      <= vout1_nxt;
			vout2_r      <= vout2_nxt;
			ctrl_r       <= ctrl_nxt;
			flags_r      <= flags_nxt;
			disch_hold_r <= disch_hold_nxt;
			enable_d_r   <= enable_now;
			soft_rst_r   <= soft_rst_nxt;
			quick_r      <= quick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux; reset bit is write-only so it never reads back
	always_comb
	begin
		ra.rdata = READ_NONE; // R13
		if (reg_hit(ra.sel, OFS_VOUT1))
			ra.rdata = {1'b0, vout1_r};
		else if (reg_hit(ra.sel, OFS_VOUT2))
			ra.rdata = vout2_r;
		else if (reg_hit(ra.sel, OFS_CTRL))
			ra.rdata = ctrl_r; // R15
		else if (reg_hit(ra.sel, OFS_FLAGS))
			ra.rdata = flags_r; // R06
	end

	// controls for the analog side
	assign first_voltage_code_o  = vout1_r;
	assign second_voltage_code_o = vout2_r[6:0];
	assign active_voltage_code_o = sel2_s ? vout2_r[6:0] : vout1_r;
	assign forced_pulse_width_switching_o = ctrl_r[B_FORCE_PWM] // R05 R10
		| (sel2_s & vout2_r[B_MODE2]);
	assign ramp_forced_pwm_o  = ctrl_r[B_RAMP_PWM]; // R08
	assign ramp_speed_o       = ctrl_r[1:0]; // R12
	assign converter_enable_o = enable_now & ~soft_rst_r; // R09 R07
	assign output_discharge_o = ~enable_now & disch_hold_r; // R11
	assign soft_restart_o     = soft_rst_r; // R07
	assign quick_restart_o    = quick_r; // R09

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	a_reset_presets: assert property ($past(srst_i) |-> vout1_r == VOUT1_RST // R04
		&& vout2_r == VOUT2_RST && ctrl_r == CTRL_RST)
		else $error("presets wrong after reset");
	a_vout1_write: assert property (wr_v1 |=> vout1_r == $past(ra.wdata[6:0])) // R14
		else $error("first code not updated by write");
	a_unmapped_zero: assert property (!reg_hit(ra.sel, OFS_VOUT1) // R13
		&& !reg_hit(ra.sel, OFS_VOUT2) && !reg_hit(ra.sel, OFS_CTRL)
		&& !reg_hit(ra.sel, OFS_FLAGS) |-> ra.rdata == READ_NONE)
		else $error("unmapped read not zero");
	a_flags_clear: assert property (rd_flags && !therm_s && !pbad_s // R06
		|=> flags_r == FLAGS_RST)
		else $error("flags not cleared by read");
	a_flag_set_wins: assert property (therm_s && !(wr_ctrl && ra.wdata[B_SRST]) // R06
		|=> flags_r[B_THERMAL])
		else $error("thermal event lost");
	a_soft_reset: assert property (wr_ctrl && ra.wdata[B_SRST] |=> soft_restart_o // R07
		&& vout1_r == VOUT1_RST && ctrl_r == CTRL_RST ##1 !soft_restart_o)
		else $error("soft reset did not restore defaults");
	a_ctrl_reserved: assert property (reg_hit(ra.sel, OFS_CTRL) // R15
		|-> !ra.rdata[B_RSVD] && !ra.rdata[B_SRST])
		else $error("reserved or reset bit reads one");
	a_quick_restart: assert property ($rose(ctrl_r[B_SW_EN]) && !$past(soft_rst_nxt) // R09
		|-> quick_restart_o)
		else $error("enable rise without restart pulse");
	a_second_pwm: assert property (sel2_s && vout2_r[B_MODE2] // R05
		|-> forced_pulse_width_switching_o)
		else $error("second selection not held in pwm");
	a_ramp_write: assert property (wr_ctrl && !ra.wdata[B_SRST] // R12
		|=> ramp_speed_o == $past(ra.wdata[1:0])
		&& ramp_forced_pwm_o == $past(ra.wdata[B_RAMP_PWM]))
		else $error("ramp fields not written");
	a_vout2_write: assert property (wr_v2 |=> vout2_r == $past(ra.wdata)) // R03 R05
		else $error("second code or mode bit not updated by write");
	a_ctrl_fields: assert property (wr_ctrl && !ra.wdata[B_SRST] // R09 R10 R11 R15
		|=> ctrl_r[B_SW_EN] == $past(ra.wdata[B_SW_EN])
		&& ctrl_r[B_FORCE_PWM] == $past(ra.wdata[B_FORCE_PWM])
		&& ctrl_r[B_DISCH] == $past(ra.wdata[B_DISCH]) && !ctrl_r[B_RSVD])
		else $error("control fields not written");
	a_sw_disable: assert property (!ctrl_r[B_SW_EN] |-> !converter_enable_o) // R09
		else $error("converter on while software disabled");
	a_discharge_off: assert property (converter_enable_o |-> !output_discharge_o) // R11
		else $error("discharge while converter on");
	a_mode_follows: assert property (!sel2_s // R05 R10
		|-> forced_pulse_width_switching_o == ctrl_r[B_FORCE_PWM])
		else $error("mode does not follow control with first selection");
	a_active_second: assert property (sel2_s // R03
		|-> active_voltage_code_o == second_voltage_code_o)
		else $error("second selection does not drive active code");
	a_pbad_sets: assert property (pbad_s && !(wr_ctrl && ra.wdata[B_SRST]) // R06
		|=> flags_r[B_PBAD])
		else $error("power bad event lost");
	a_quick_single: assert property (quick_restart_o |=> !quick_restart_o) // R09
		else $error("restart pulse longer than one cycle");
	a_discharge_hold: assert property (enable_d_r && !enable_now // R11
		|=> output_discharge_o == $past(ctrl_r[B_DISCH]))
		else $error("discharge not latched at disable");

	c_write_v2: cover property (wr_v2);
	c_read_flags: cover property (rd_flags && flags_r != FLAGS_RST);
	c_soft_reset: cover property (soft_restart_o);
	c_disable_cycle: cover property (enable_d_r && !enable_now);
	c_quick_restart: cover property (quick_restart_o);
endmodule

// file: rtl/regbank_pkg.sv
// How it works
// [R01] The first byte after a start must match a fixed 7-bit address, top bit one; bit 0 is direction.
// [R02] After the address acknowledge a select byte follows, upper five bits zero, low three the register.
// [R03] Both voltage registers hold a 7-bit code in bits 6 to 0, linear from 0.400 V to 1.9875 V.
// [R04] Register reset loads code 0x10 into the first voltage register and 0x38 into the second.
// [R05] Bit 7 of the second voltage register forces PWM while that voltage is selected.
// [R06] The flag register at 0x05 resets to zero, returns its flags on a read and that read clears them.
// [R07] Writing one to control bit 7 restores all defaults, shuts down, reloads settings and restarts.
// [R08] Control bit 6, default one, forces PWM during an output voltage change.
// [R09] Control bit 5, default one, is a software enable that keeps registers and restarts with no wait.
// [R10] Control bit 4, default zero, picks power save at light load when zero, forced PWM when one.
// [R11] Control bit 3, default one, enables output discharge, applied at the next disable of either kind.
// [R12] Control bits 1 to 0, default 11, pick the ramp slope: 10, 5, 1 or 0.1 mV per microsecond.
// [R13] A read from any undefined offset returns 00h.
// [R14] A written byte takes effect when the acknowledge after that data byte ends.
// [R15] Control bit 2 ignores writes and reads back as zero.
package regbank_pkg;
	// target address, value arbitrary apart from the top bit
	localparam logic [6:0] DEV_ADDR     = 7'h48;
	localparam logic [7:0] OFS_VOUT1    = 8'h01;
	localparam logic [7:0] OFS_VOUT2    = 8'h02;
	localparam logic [7:0] OFS_CTRL     = 8'h03;
	localparam logic [7:0] OFS_FLAGS    = 8'h05;
	localparam logic [6:0] VOUT1_RST    = 7'h10;
	localparam logic [7:0] VOUT2_RST    = 8'h38;
	localparam logic [7:0] CTRL_RST     = 8'h6B;
	localparam logic [7:0] FLAGS_RST    = 8'h00;
	localparam logic [7:0] READ_NONE    = 8'h00;
	localparam int         B_MODE2      = 7;
	localparam int         B_SRST       = 7;
	localparam int         B_RAMP_PWM   = 6;
	localparam int         B_SW_EN      = 5;
	localparam int         B_FORCE_PWM  = 4;
	localparam int         B_DISCH      = 3;
	localparam int         B_RSVD       = 2;
	localparam int         B_THERMAL    = 4;
	localparam int         B_PBAD       = 2;
	localparam logic [3:0] BITS_BYTE    = 4'h8;
	localparam logic [3:0] BIT_LAST     = 4'h7;
	// idle levels of scl, sda, enable, select, thermal and power bad, in that order
	localparam logic [5:0] PIN_IDLE     = 6'h30;

	// full-byte compare, so nonzero upper select bits hit nothing
	function automatic logic reg_hit(input logic [7:0] sel, input logic [7:0] ofs);
		reg_hit = (sel == ofs);
	endfunction
endpackage

// file: rtl/reg_access_if.sv
`timescale 1ns/1ps
// register strobes between the serial engine and the bank
interface reg_access_if;
	logic       wr_stb;
	logic       rd_stb;
	logic [7:0] sel;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport engine (output wr_stb, output rd_stb, output sel, output wdata, input rdata);
	modport bank   (input wr_stb, input rd_stb, input sel, input wdata, output rdata);
endinterface

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	input  wire logic         clock_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// two stages; only the second is read outside
	always_comb
	begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			// idle levels, so no false edge or start follows reset
			meta_r <= INIT;
			q_r    <= INIT;
		end
		else
		begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule

// file: rtl/i2c_target_engine.sv
`timescale 1ns/1ps
module i2c_target_engine (
	input  wire logic     clock_i,
	input  wire logic     srst_i,
	input  wire logic     scl_i,
	input  wire logic     sda_i,
	output logic          sda_oe_o,
	reg_access_if.engine  ra
);
	import regbank_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_WDAT, ST_WACK, ST_RDAT, ST_MACK
	} eng_state_t;

	eng_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] sel_r, sel_nxt;
	logic       rw_r, rw_nxt;
	logic       drv_r, drv_nxt;
	logic       scl_d_r;
	logic       sda_d_r;
	logic       rise, fall, start, stop;

	// bus conditions from already synchronised pins
	assign rise  = scl_i & ~scl_d_r;
	assign fall  = ~scl_i & scl_d_r;
	assign start = scl_i & scl_d_r & sda_d_r & ~sda_i;
	assign stop  = scl_i & scl_d_r & ~sda_d_r & sda_i;

	////////////////////////////////////////////////////////////////////////////
	// byte sequencing
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		shift_nxt = shift_r;
		sel_nxt   = sel_r;
		rw_nxt    = rw_r;
		drv_nxt   = drv_r;
		ra.wr_stb = 1'b0;
		ra.rd_stb = 1'b0;
		if (start)
		begin
			state_nxt = ST_ADDR;
			cnt_nxt   = '0;
			drv_nxt   = 1'b0;
		end
		else if (stop)
		begin
			state_nxt = ST_IDLE;
			drv_nxt   = 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_ADDR, ST_REG, ST_WDAT:
				begin
					if (rise)
					begin
						shift_nxt = {shift_r[6:0], sda_i};
						cnt_nxt   = cnt_r + 4'h1;
					end
					else if (fall && cnt_r == BITS_BYTE)
					begin
						cnt_nxt = '0;
						drv_nxt = 1'b1;
						if (state_r == ST_ADDR)
						begin
							// foreign address: stay off the bus until next start
							rw_nxt    = shift_r[0]; // R01
							drv_nxt   = (shift_r[7:1] == DEV_ADDR); // R01
							state_nxt = drv_nxt ? ST_AACK : ST_IDLE;
						end
						else
							state_nxt = (state_r == ST_REG) ? ST_RACK : ST_WACK;
					end
				end
				ST_AACK:
				begin
					if (fall)
					begin
						if (rw_r)
						begin
							shift_nxt = ra.rdata;
							ra.rd_stb = 1'b1;
							drv_nxt   = ~ra.rdata[7];
							state_nxt = ST_RDAT;
						end
						else
						begin
							drv_nxt   = 1'b0;
							state_nxt = ST_REG;
						end
					end
				end
				ST_RACK:
				begin
					if (fall)
					begin
						sel_nxt   = shift_r; // R02
						drv_nxt   = 1'b0;
						state_nxt = ST_WDAT;
					end
				end
				ST_WACK:
				begin
					if (fall)
					begin
						ra.wr_stb = 1'b1; // R14
						drv_nxt   = 1'b0;
						state_nxt = ST_WDAT;
					end
				end
				ST_RDAT:
				begin
					if (fall)
					begin
						shift_nxt = {shift_r[6:0], 1'b0};
						cnt_nxt   = cnt_r + 4'h1;
						drv_nxt   = ~shift_r[6];
						if (cnt_r == BIT_LAST)
						begin
							cnt_nxt   = '0;
							drv_nxt   = 1'b0;
							state_nxt = ST_MACK;
						end
					end
				end
				ST_MACK:
				begin
					// a not-acknowledge ends the read; wait for stop
					if (rise)
					begin
						cnt_nxt   = {3'h0, ~sda_i};
						state_nxt = sda_i ? ST_IDLE : ST_MACK;
					end
					else if (fall && cnt_r[0])
					begin
						shift_nxt = ra.rdata;
						ra.rd_stb = 1'b1;
						drv_nxt   = ~ra.rdata[7];
						cnt_nxt   = '0;
						state_nxt = ST_RDAT;
					end
				end
				default:
				begin
					drv_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			shift_r <= '0;
			sel_r   <= '0;
			rw_r    <= 1'b0;
			drv_r   <= 1'b0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			shift_r <= shift_nxt;
			sel_r   <= sel_nxt;
			rw_r    <= rw_nxt;
			drv_r   <= drv_nxt;
			scl_d_r <= scl_i;
			sda_d_r <= sda_i;
		end
	end

	assign ra.sel    = sel_r;
	assign ra.wdata  = shift_r;
	assign sda_oe_o  = drv_r;
endmodule

// file: tb/i2c_ctrl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// bus controller: scl idles high between frames, a released sda rises by pull-up
module i2c_ctrl_model (
	output logic      scl_o,
	output logic      pull_o,
	input  wire logic sda_i
);
	localparam time Q = 40ns;

	// both lines released at power-up
	initial
	begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end

	////////////////////////////////////////
	// start or repeated start: sda falls while scl is high
	task automatic start();
		pull_o = 1'b0;
		#Q;
		scl_o = 1'b1;
		#Q;
		pull_o = 1'b1;
		#Q;
		scl_o = 1'b0;
		#Q;
	endtask

	// data moves only while scl is low, so no false start or stop
	task automatic bit_xfer(input logic b, output logic r);
		pull_o = ~b;
		#Q;
		scl_o = 1'b1;
		#Q;
		r = sda_i;
		#Q;
		scl_o = 1'b0;
		#Q;
	endtask

	// msb first; the ninth bit carries the acknowledge either way
	task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], q[i]);
		bit_xfer(ack_in, ack_out);
	endtask

	// stop: sda rises while scl is high, bus left idle
	task automatic stop();
		pull_o = 1'b1;
		#Q;
		scl_o = 1'b1;
		#Q;
		pull_o = 1'b0;
		#(2*Q);
	endtask
endmodule

// file: tb/buck_regulator_i2c_register_bank_tb.sv
`timescale 1ns/1ps
module buck_regulator_i2c_register_bank_tb;
	import regbank_pkg::*;

	logic       clock_i, srst_i, hw_enable_i, select_second_i, thermal_trip_i, power_bad_i;
	logic       scl, pull, sda, sda_o, sda_oe_o, a;
	logic [7:0] q;
	logic [6:0] first_voltage_code_o, second_voltage_code_o, active_voltage_code_o;
	logic       forced_pulse_width_switching_o, ramp_forced_pwm_o, converter_enable_o;
	logic       output_discharge_o, soft_restart_o, quick_restart_o;
	logic [1:0] ramp_speed_o;
	int         fail_count, checks_done, soft_n, quick_n;

	buck_regulator_i2c_register_bank uut (
		.clock_i, .srst_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
		.hw_enable_i, .select_second_i, .thermal_trip_i, .power_bad_i,
		.first_voltage_code_o, .second_voltage_code_o, .active_voltage_code_o,
		.forced_pulse_width_switching_o, .ramp_forced_pwm_o, .ramp_speed_o,
		.converter_enable_o, .output_discharge_o, .soft_restart_o, .quick_restart_o
	);

	i2c_ctrl_model ctrl (
		.scl_o (scl),
		.pull_o(pull),
		.sda_i (sda)
	);

	// open-drain wire with pull-up: low if either side pulls
	assign sda = ~(sda_oe_o | pull);

	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// restart pulses stand one cycle only, so count them mid-cycle where they are settled
	always @(negedge clock_i)
	begin
		if (soft_restart_o === 1'b1)
			soft_n++;
		if (quick_restart_o === 1'b1)
			quick_n++;
	end

	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// address with write direction, then the select byte
	task automatic head(input logic [7:0] sel);
		ctrl.start();
		ctrl.byte_xfer({DEV_ADDR, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		ctrl.byte_xfer(sel, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
	endtask

	// settle lets the synced ack fall land before ports are compared
	task automatic wr(input logic [7:0] sel, input logic [7:0] d);
		head(sel);
		ctrl.byte_xfer(d, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		ctrl.stop();
		repeat (6) @(negedge clock_i);
	endtask

	// single byte read closed with a nack
	task automatic rd(input logic [7:0] sel, input logic [7:0] exp);
		head(sel);
		ctrl.start();
		ctrl.byte_xfer({DEV_ADDR, 1'b1}, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		ctrl.byte_xfer(8'hFF, 1'b1, q, a);
		ctrl.stop();
		chk(q, exp);
	endtask

	task automatic end_of_test();
		$display("mismatches %0d of %0d comparisons", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// a hung bus sequence is cut short here
	initial
	begin
		#400000;
		fail_count++;
		end_of_test();
	end

	////////////////////////////////////////
	initial
	begin
		fail_count = 0;
		checks_done = 0;
		soft_n = 0;
		quick_n = 0;
		srst_i = 1'b1;
		hw_enable_i = 1'b1;
		select_second_i = 1'b0;
		thermal_trip_i = 1'b0;
		power_bad_i = 1'b0;
		repeat (12) @(negedge clock_i);
		srst_i = 1'b0;
		repeat (8) @(negedge clock_i);
		chk({1'b0, first_voltage_code_o}, 8'h10);
		chk({1'b0, second_voltage_code_o}, 8'h38);
		chk({6'h0, ramp_speed_o}, 8'h03);
		chk({7'h0, ramp_forced_pwm_o}, 8'h01);
		chk({7'h0, forced_pulse_width_switching_o}, 8'h00);
		chk({7'h0, converter_enable_o}, 8'h01);
		chk({7'h0, sda_o}, 8'h00);
		rd(OFS_VOUT1, 8'h10);
		rd(OFS_VOUT2, 8'h38);
		rd(OFS_CTRL, 8'h6B);
		rd(OFS_FLAGS, 8'h00);
		for (int s = 0; s < 8; s++)
			if (s != 1 && s != 2 && s != 3 && s != 5)
				rd(8'(s), 8'h00);
		// a foreign address is left unacknowledged
		ctrl.start();
		ctrl.byte_xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
		ctrl.stop();
		chk({7'h0, a}, 8'h01);
		// extreme codes and the per-selection mode bit
		wr(OFS_VOUT1, 8'h7F);
		wr(OFS_VOUT2, 8'h80);
		chk({1'b0, first_voltage_code_o}, 8'h7F);
		chk({1'b0, active_voltage_code_o}, 8'h7F);
		chk({7'h0, forced_pulse_width_switching_o}, 8'h00);
		select_second_i = 1'b1;
		repeat (6) @(negedge clock_i);
		chk({1'b0, active_voltage_code_o}, 8'h00);
		chk({7'h0, forced_pulse_width_switching_o}, 8'h01);
		rd(OFS_VOUT2, 8'h80);
		select_second_i = 1'b0;
		// nonzero upper select bits must hit nothing
		wr(8'h81, 8'h55);
		rd(OFS_VOUT1, 8'h7F);
		rd(8'h81, 8'h00);
		// every ramp slope, reserved bit written high each time
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_CTRL, 8'h6C | 8'(k));
			chk({6'h0, ramp_speed_o}, 8'(k));
			rd(OFS_CTRL, 8'h68 | 8'(k));
		end
		wr(OFS_CTRL, 8'h3B);
		chk({7'h0, ramp_forced_pwm_o}, 8'h00);
		chk({7'h0, forced_pulse_width_switching_o}, 8'h01);
		// software disable with discharge cleared beforehand
		wr(OFS_CTRL, 8'h63);
		wr(OFS_CTRL, 8'h43);
		chk({7'h0, converter_enable_o}, 8'h00);
		chk({7'h0, output_discharge_o}, 8'h00);
		rd(OFS_VOUT1, 8'h7F);
		wr(OFS_CTRL, 8'h6B);
		chk(8'(quick_n), 8'h01);
		chk({7'h0, converter_enable_o}, 8'h01);
		// hardware disable applies the stored discharge setting
		hw_enable_i = 1'b0;
		repeat (6) @(negedge clock_i);
		chk({7'h0, converter_enable_o}, 8'h00);
		chk({7'h0, output_discharge_o}, 8'h01);
		hw_enable_i = 1'b1;
		repeat (6) @(negedge clock_i);
		// events latch until read, then the read clears them
		thermal_trip_i = 1'b1;
		power_bad_i = 1'b1;
		repeat (4) @(negedge clock_i);
		thermal_trip_i = 1'b0;
		power_bad_i = 1'b0;
		repeat (6) @(negedge clock_i);
		rd(OFS_FLAGS, 8'h14);
		rd(OFS_FLAGS, 8'h00);
		// soft reset returns every default
		wr(OFS_CTRL, 8'h80);
		chk(8'(soft_n), 8'h01);
		chk({1'b0, first_voltage_code_o}, 8'h10);
		rd(OFS_VOUT2, 8'h38);
		rd(OFS_CTRL, 8'h6B);
		end_of_test();
	end
endmodule
